// *** dv/wdrm_top_bench.sv ***
/*
 Self-checking bench of the watchdog and reset monitor.
 Assumes wdrm_top with its bound checker; the bench drives every port itself.
*/
`timescale 1ns/1ps
`include "wdrm_defs.svh"

module wdrm_top_bench
    import wdrm_pkg::*;
();
    localparam wdrm_instr_t SRV = 4'h8, EOI = 4'h4, SOFT = 4'h2, DIS = 4'h1;
    logic          clk, reset, pinDrv, bidirResetEn, powerUpDetect, prb;
    logic          rdSeen = 1'b0, crPrev = 1'b0;
    wdrm_sfr_req_t sfrReq;
    wdrm_instr_t   instr;
    logic [15:0]   sfrRdData, timerCount, fl;
    logic          resetInPinOut, resetInPinOe, resetOutPin_n, chipReset, timerRunning;
    logic [15:0]   rdQ[$];
    logic          runQ[$];
    int            perQ[$];
    int            failures, totalChecks, cyc, srvCnt;
    logic [7:0]    rel;

    wdrm_top wdrm_top_i (
        .clk(clk), .reset(reset), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .instr(instr),
        .resetInPin_n(pinDrv & ~resetInPinOe), .resetInPinOut(resetInPinOut), .resetInPinOe(resetInPinOe),
        .bidirResetEn(bidirResetEn), .powerUpDetect(powerUpDetect), .resetOutPin_n(resetOutPin_n),
        .chipReset(chipReset), .timerCount(timerCount), .timerRunning(timerRunning));

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
        totalChecks++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask : check
    task automatic wrReg(input logic [15:0] d, input logic [1:0] be = 2'b11);
        sfrReq = '{rd: 1'b0, wr: 1'b1, addr: `WDRM_CTRL_ADDR, byteEn: be, wrData: d};
        tick();
        sfrReq.wr = 1'b0;
        tick();
    endtask : wrReg
    task automatic rdReg(input logic [15:0] a, input logic [15:0] e);
        rdQ.push_back(e);
        sfrReq.rd = 1'b1;
        sfrReq.addr = a;
        tick();
        sfrReq.rd = 1'b0;
        tick();
    endtask : rdReg
    task automatic strobe(input wdrm_instr_t v);
        instr = v;
        tick();
        instr = '0;
        tick();
    endtask : strobe
    task automatic probe(input logic e);
        runQ.push_back(e);
        prb = 1'b1;
        tick();
        prb = 1'b0;
        tick();
    endtask : probe
    // Bounded by the global cycle ceiling, so a stuck reset cannot hang the run
    task automatic waitLvl(input logic v);
        while (chipReset !== v) tick();
    endtask : waitLvl
    task finish_test;
        if (failures == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Result watcher: read data one cycle after the strobe, timeout at the rise of chip reset
    always @(posedge clk) begin
        if (rdSeen) check("sfrRdData", rdQ.pop_front(), sfrRdData);
        if (prb) check("timerRunning", runQ.pop_front(), timerRunning);
        srvCnt = instr.serviceTimerInstr ? 0 : srvCnt + 1;
        if (chipReset === 1'b1 && crPrev === 1'b0 && perQ.size() > 0) begin
            check("timeout", 1'b1, srvCnt >= perQ[0] && srvCnt <= perQ[0] + 2);
            void'(perQ.pop_front());
        end
        rdSeen = sfrReq.rd;
        crPrev = chipReset;
        cyc++;
        if (cyc == 90000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(54));
        reset = 1'b1;
        sfrReq = '0;
        instr = '0;
        pinDrv = 1'b1;
        bidirResetEn = 1'b0;
        powerUpDetect = 1'b0;
        prb = 1'b0;
        tick(20);
        reset = 1'b0;
        tick();
        rdReg(`WDRM_CTRL_ADDR, 16'h0000);
        rdReg(16'h1234, 16'h0000);
        probe(1'b1);
        strobe(DIS);
        probe(1'b0);
        strobe(SOFT);
        waitLvl(1'b1);
        waitLvl(1'b0);
        rdReg(`WDRM_CTRL_ADDR, 16'h0004);
        probe(1'b1);
        strobe(EOI);
        strobe(DIS);
        probe(1'b1);
        rdReg(`WDRM_CTRL_ADDR, 16'h0000);
        fl = 16'h0000;
        for (int p = 0; p < 2; p++) begin
            rel = p ? 8'hFF : 8'hF0 + 8'($urandom_range(15));
            wrReg({rel, 8'h3E | 8'(p)});
            // Low byte only: the reload byte must survive
            wrReg({~rel, 8'(p)}, 2'b01);
            rdReg(`WDRM_CTRL_ADDR, {rel, 8'(p)} | fl);
            perQ.push_back(512 * (1 + 63 * p) * (256 - rel));
            strobe(SRV);
            rdReg(`WDRM_CTRL_ADDR, {rel, 8'(p)} | (fl & 16'h0004));
            waitLvl(1'b1);
            waitLvl(1'b0);
            fl = 16'h0006;
            rdReg(`WDRM_CTRL_ADDR, fl);
        end
        strobe(EOI);
        rdReg(`WDRM_CTRL_ADDR, 16'h0000);
        pinDrv = 1'b0;
        tick(10);
        pinDrv = 1'b1;
        waitLvl(1'b1);
        waitLvl(1'b0);
        rdReg(`WDRM_CTRL_ADDR, 16'h000C);
        strobe(EOI);
        for (int u = 1; u >= 0; u--) begin
            powerUpDetect = u[0];
            pinDrv = 1'b0;
            tick(600);
            pinDrv = 1'b1;
            tick(4);
            waitLvl(1'b0);
            rdReg(`WDRM_CTRL_ADDR, u ? 16'h003C : 16'h001C);
            strobe(EOI);
        end
        // Pin held low past the sequence end turns a soft reset into a long one
        bidirResetEn = 1'b1;
        strobe(SOFT);
        waitLvl(1'b1);
        tick(300);
        pinDrv = 1'b0;
        tick(400);
        pinDrv = 1'b1;
        waitLvl(1'b0);
        rdReg(`WDRM_CTRL_ADDR, 16'h001C);
        tick(4);
        finish_test();
    end
endmodule : wdrm_top_bench

// *** dv/wdrm_top_props.sv ***
/*
 Port checker of the watchdog and reset monitor.
 Assumes it is bound to wdrm_top and that wdrm_defs.svh gives the register offset.
*/
`timescale 1ns/1ps
`include "wdrm_defs.svh"

module wdrm_top_props
    import wdrm_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // Observed ports
    input  wire wdrm_sfr_req_t sfrReq,
    input  wire logic [15:0]   sfrRdData,
    input  wire wdrm_instr_t   instr,
    input  wire logic          resetInPinOut,
    input  wire logic          resetInPinOe,
    input  wire logic          resetOutPin_n,
    input  wire logic          chipReset,
    input  wire logic [15:0]   timerCount
);
    logic [7:0]  relShadow_r;
    logic [15:0] hiLen_r;
    logic        regSel;

    assign regSel = (sfrReq.addr == `WDRM_CTRL_ADDR);

    // Shadow of the reload byte; an internal reset puts it back to zero
    always_ff @(posedge clk) begin
        if (reset || chipReset)
            relShadow_r <= 8'h00;
        else if (sfrReq.wr && regSel && sfrReq.byteEn[1])
            relShadow_r <= sfrReq.wrData[15:8];
    end

    // Length of the current internal reset, saturating so it never wraps
    always_ff @(posedge clk) begin
        if (reset || !chipReset)
            hiLen_r <= 16'h0000;
        else if (hiLen_r != 16'hFFFF)
            hiLen_r <= hiLen_r + 16'h0001;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    chk_out_pair: assert property (resetOutPin_n == !chipReset)
        else $error("reset output pin disagrees with chip reset");
    chk_ovf_reset: assert property ($past(timerCount) == 16'hFFFF && timerCount == 16'h0000 |-> ##[0:1] chipReset)
        else $error("wrap of the counter without internal reset");
    chk_seq_length: assert property ($fell(chipReset) |-> hiLen_r >= 16'h0200)
        else $error("internal reset shorter than 512 cycles");
    chk_srv_reload: assert property (instr.serviceTimerInstr && !chipReset |->
        ##2 timerCount[15:8] == $past(relShadow_r, 2) && timerCount[7:0] <= 8'h01)
        else $error("service did not reload the upper byte");
    chk_count_up: assert property ($changed(timerCount) && !$past(instr.serviceTimerInstr, 2)
        && !$past(chipReset) && !$past(chipReset, 2) |-> timerCount == $past(timerCount) + 16'h0001)
        else $error("counter moved other than by one upward");
    chk_read_rel: assert property (sfrReq.rd && regSel |=> sfrRdData[15:8] == $past(relShadow_r))
        else $error("read reload byte differs from last write");
    chk_read_zero: assert property (!(sfrReq.rd && regSel) |=> sfrRdData == 16'h0000)
        else $error("read data not zero outside a register read");
    chk_pin_drive: assert property (resetInPinOe |-> chipReset && !resetInPinOut)
        else $error("reset pin pulled outside an internal reset");
endmodule : wdrm_top_props

bind wdrm_top wdrm_top_props wdrm_top_props_i (
    .clk(clk), .reset(reset), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .instr(instr),
    .resetInPinOut(resetInPinOut), .resetInPinOe(resetInPinOe), .resetOutPin_n(resetOutPin_n),
    .chipReset(chipReset), .timerCount(timerCount));

// *** hdl/wdrm_defs.svh ***
/*
 Constants of the watchdog and reset monitor: register offset, field positions,
 reset values and timing counts. Assumes a 250 MHz CPU clock on clk.
*/
`ifndef WDRM_DEFS_SVH
`define WDRM_DEFS_SVH

// Register offset in the special function register space
`define WDRM_CTRL_ADDR          16'hFFAE

// Field positions of the control and reset source register
`define WDRM_PRESC_BIT          0
`define WDRM_OVF_FLAG_BIT       1
`define WDRM_SOFT_FLAG_BIT      2
`define WDRM_SHORT_FLAG_BIT     3
`define WDRM_LONG_FLAG_BIT      4
`define WDRM_PWR_FLAG_BIT       5
`define WDRM_RELOAD_LSB         8
`define WDRM_RELOAD_MSB         15

// Reset values
`define WDRM_RELOAD_RST         8'h00
`define WDRM_PRESC_RST          1'b0
`define WDRM_FLAGS_RST          5'h00
`define WDRM_COUNT_RST          16'h0000

// Prescale ratios, in CPU clocks per timer step
`define WDRM_DIV_FAST           8'h02
`define WDRM_DIV_SLOW           8'h80

// Reset pin timing, in CPU clocks (one CPU clock is two TCL)
`define WDRM_PIN_MIN_CYC        10'h002
`define WDRM_PIN_LONG_CYC       10'h208
`define WDRM_SEQ_CYC            10'h200

`endif

// *** hdl/wdrm_pkg.sv ***
/*
 Types of the watchdog and reset monitor: bus request, instruction strobes,
 sequencer states and reset sources. Its encodings are written out here, not taken from wdrm_defs.svh.
*/
package wdrm_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [1:0]  byteEn;
        logic [15:0] wrData;
    } wdrm_sfr_req_t;

    typedef struct packed {
        logic serviceTimerInstr;
        logic endOfInit;
        logic softResetInstr;
        logic disableInstr;
    } wdrm_instr_t;

    typedef enum logic [3:0] {
        ST_RUN    = 4'b0001,
        ST_PIN    = 4'b0010,
        ST_SEQ    = 4'b0100,
        ST_EXTEND = 4'b1000
    } wdrm_state_t;

    typedef enum logic [2:0] {
        SRC_NONE  = 3'h0,
        SRC_POWER = 3'h1,
        SRC_LONG  = 3'h2,
        SRC_SHORT = 3'h3,
        SRC_SOFT  = 3'h4,
        SRC_WDOG  = 3'h5
    } wdrm_src_t;

endpackage : wdrm_pkg

// *** hdl/wdrm_prescaler.sv ***
/*
 Prescaler of the watchdog timer: one step pulse every 2 or 128 CPU clocks.
 Assumes the caller restarts it on each service so the period is exact.
*/
`timescale 1ns/1ps
`include "wdrm_defs.svh"

module wdrm_prescaler
    import wdrm_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Control
    input  wire logic run,
    input  wire logic restart,
    input  wire logic slowSel,
    // Step output
    output logic      stepPulse
);

    logic [6:0] divCount_r;
    logic [6:0] divLast;

    assign divLast   = 7'((slowSel ? `WDRM_DIV_SLOW : `WDRM_DIV_FAST) - 8'h01);
    assign stepPulse = run && !restart && (divCount_r == divLast);

    always_ff @(posedge clk) begin
        if (reset || restart || !run) begin
            divCount_r <= 7'h00;
        end else if (divCount_r >= divLast) begin
            divCount_r <= 7'h00;
        end else begin
            divCount_r <= divCount_r + 7'h01;
        end
    end

endmodule : wdrm_prescaler

// *** hdl/wdrm_top.sv ***
/*
 Watchdog timer with reset source indication and reset pin sequencer.
 Assumes the CPU core raises one-cycle instruction strobes, the register port is
 a simple synchronous strobe port, and all pins are synchronous to clk.
*/
// What this block does
// - After every chip reset the watchdog runs, and a disable request counts only before end of initialisation.
// - An unserviced overflow starts an internal reset and drives the reset output pin low.
// - The timer steps at the CPU clock divided by 2, or by 128 when prescale select is set.
// - The counter is 16 bits and each service reloads its upper byte with the reload byte.
// - The timeout is 512 CPU clocks, times 64 on the slow prescale, times 256 minus the reload byte.
// - The overflow flag is set by an overflow with bidirectional reset off, and cleared by a pin reset or a service.
// - The soft reset flag is set by the soft reset instruction and cleared by end of initialisation.
// - The short and long pin flags are set by reset pin pulses by class and cleared by end of initialisation.
// - The power up flag is set through the reset pin only with power up detected, cleared by end of initialisation.
// - Register writes never change a reset indication flag.
// - Several flags may be set together and end of initialisation clears them all.
// - Each reset source raises its own documented set of flags.
// - With bidirectional reset on and the pin still low after the sequence, the reset becomes a long one.
`timescale 1ns/1ps
`include "wdrm_defs.svh"

module wdrm_top
    import wdrm_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // Register port
    input  wire wdrm_sfr_req_t sfrReq,
    output logic [15:0]        sfrRdData,
    // Instruction strobes from the core
    input  wire wdrm_instr_t   instr,
    // Reset input pin, two-way for the bidirectional function
    input  wire logic          resetInPin_n,
    output logic               resetInPinOut,
    output logic               resetInPinOe,
    // System configuration inputs
    input  wire logic          bidirResetEn,
    input  wire logic          powerUpDetect,
    // Reset outputs
    output logic               resetOutPin_n,
    output logic               chipReset,
    // Status
    output logic [15:0]        timerCount,
    output logic               timerRunning
);

    wdrm_state_t state_r;
    wdrm_state_t state_nxt;
    wdrm_src_t   src_r;
    wdrm_src_t   src_nxt;
    logic [9:0]  seqCount_r;
    logic [7:0]  reloadHighByte_r;
    logic        inputPrescaleSelect_r;
    logic [4:0]  flags_r;
    logic [15:0] count_r;
    logic        endOfInitDone_r;
    logic        disabled_r;
    logic        stepPulse;
    logic        overflow;
    logic        running;
    logic        serviceNow;
    logic        ctrlWrite;
    logic        seqDone;
    logic        pinLow;
    logic [4:0]  setMask;
    logic [4:0]  clrMask;
    logic        applyFlags;
    logic        resetInPinOut_r;
    logic        resetInPinOe_r;
    logic        resetOutPin_n_r;
    logic        chipReset_r;
    logic [15:0] sfrRdData_r;

    assign pinLow     = !resetInPin_n;
    assign running    = (state_r == ST_RUN) && !disabled_r;
    assign serviceNow = (state_r == ST_RUN) && instr.serviceTimerInstr;
    assign ctrlWrite  = sfrReq.wr && (sfrReq.addr == `WDRM_CTRL_ADDR) && (state_r == ST_RUN);
    assign seqDone    = (seqCount_r == `WDRM_SEQ_CYC - 10'h001);
    assign overflow   = running && stepPulse && (count_r == 16'hFFFF);

    wdrm_prescaler u_prescaler (
        .clk       (clk),
        .reset     (reset),
        .run       (running),
        .restart   (serviceNow),
        .slowSel   (inputPrescaleSelect_r),
        .stepPulse (stepPulse)
    );

    // Control fields; flags are not writable here
    always_ff @(posedge clk) begin
        if (reset || state_r != ST_RUN) begin
            reloadHighByte_r      <= `WDRM_RELOAD_RST;
            inputPrescaleSelect_r <= `WDRM_PRESC_RST;
        end else if (ctrlWrite) begin
            if (sfrReq.byteEn[1]) begin
                reloadHighByte_r <= sfrReq.wrData[`WDRM_RELOAD_MSB:`WDRM_RELOAD_LSB];
            end
            if (sfrReq.byteEn[0]) begin
                inputPrescaleSelect_r <= sfrReq.wrData[`WDRM_PRESC_BIT];
            end
        end
    end

    // Initialisation window and disable request
    always_ff @(posedge clk) begin
        if (reset || state_r != ST_RUN) begin
            endOfInitDone_r <= 1'b0;
            disabled_r      <= 1'b0;
        end else begin
            if (instr.endOfInit) begin
                endOfInitDone_r <= 1'b1;
            end
            // A disable in the same cycle as end of init still lands before it
            if (instr.disableInstr && !endOfInitDone_r) begin
                disabled_r <= 1'b1;
            end
        end
    end

    // Timer counter; the low byte restarts at zero so the period is exact
    always_ff @(posedge clk) begin
        if (reset || state_r != ST_RUN) begin
            count_r <= `WDRM_COUNT_RST;
        end else if (serviceNow) begin
            count_r <= {reloadHighByte_r, 8'h00};
        end else if (running && stepPulse) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Reset sequencer
    always_comb begin
        state_nxt = state_r;
        src_nxt   = src_r;
        case (state_r)
            ST_RUN: begin
                if (pinLow) begin
                    state_nxt = ST_PIN;
                    src_nxt   = SRC_NONE;
                end else if (overflow) begin
                    state_nxt = ST_SEQ;
                    src_nxt   = SRC_WDOG;
                end else if (instr.softResetInstr) begin
                    state_nxt = ST_SEQ;
                    src_nxt   = SRC_SOFT;
                end
            end
            ST_PIN: begin
                if (!pinLow) begin
                    if (seqCount_r >= `WDRM_PIN_LONG_CYC) begin
                        state_nxt = ST_RUN;
                        src_nxt   = powerUpDetect ? SRC_POWER : SRC_LONG;
                    end else if (seqCount_r >= `WDRM_PIN_MIN_CYC) begin
                        state_nxt = ST_SEQ;
                        src_nxt   = SRC_SHORT;
                    end else begin
                        // Glitch too short to be a reset
                        state_nxt = ST_RUN;
                        src_nxt   = SRC_NONE;
                    end
                end
            end
            ST_SEQ: begin
                if (seqDone) begin
                    if (bidirResetEn && pinLow) begin
                        state_nxt = ST_EXTEND;
                        src_nxt   = SRC_LONG;
                    end else begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_EXTEND: begin
                if (!pinLow) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
                src_nxt   = SRC_NONE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_RUN;
            src_r   <= SRC_NONE;
        end else begin
            state_r <= state_nxt;
            src_r   <= src_nxt;
        end
    end

    // Pulse width and internal sequence counter
    always_ff @(posedge clk) begin
        if (reset || state_nxt != state_r) begin
            seqCount_r <= 10'h000;
        end else if (seqCount_r != 10'h3FF) begin
            seqCount_r <= seqCount_r + 10'h001;
        end
    end

    // Flags are applied when the reset sequence ends and the chip resumes
    assign applyFlags = (state_r != ST_RUN) && (state_nxt == ST_RUN);

    always_comb begin
        setMask = 5'h00;
        clrMask = 5'h00;
        if (applyFlags) begin
            case (src_nxt)
                SRC_POWER: setMask = 5'b11110;
                SRC_LONG:  setMask = 5'b01110;
                SRC_SHORT: setMask = 5'b00110;
                SRC_SOFT:  setMask = 5'b00010;
                SRC_WDOG:  setMask = 5'b00011;
                default:   setMask = 5'h00;
            endcase
            if (src_nxt == SRC_POWER || src_nxt == SRC_LONG || src_nxt == SRC_SHORT) begin
                clrMask[`WDRM_OVF_FLAG_BIT - 1] = 1'b1;
            end
        end
        if (state_r == ST_RUN && instr.endOfInit) begin
            clrMask = 5'h1F;
        end
        if (serviceNow) begin
            clrMask[`WDRM_OVF_FLAG_BIT - 1] = 1'b1;
        end
    end

    // Bit 0 overflow, 1 soft, 2 short, 3 long, 4 power; a set beats a clear
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_r <= `WDRM_FLAGS_RST;
        end else begin
            flags_r <= (flags_r & ~clrMask) | setMask;
        end
    end

    // Pins and reset outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            resetOutPin_n_r <= 1'b1;
            chipReset_r     <= 1'b0;
            resetInPinOut_r <= 1'b0;
            resetInPinOe_r  <= 1'b0;
        end else begin
            resetOutPin_n_r <= (state_nxt == ST_RUN);
            chipReset_r     <= (state_nxt != ST_RUN);
            resetInPinOut_r <= 1'b0;
            // Pull-down for the whole internal sequence, still on when the pin is sampled at its end
            resetInPinOe_r  <= bidirResetEn && (state_nxt == ST_SEQ) && !(state_r == ST_SEQ && seqDone);
        end
    end

    // Register read
    always_ff @(posedge clk) begin
        if (reset) begin
            sfrRdData_r <= 16'h0000;
        end else if (sfrReq.rd && sfrReq.addr == `WDRM_CTRL_ADDR) begin
            sfrRdData_r <= {reloadHighByte_r, 2'b00, flags_r, inputPrescaleSelect_r};
        end else begin
            sfrRdData_r <= 16'h0000;
        end
    end

    // Status outputs, registered
    logic [15:0] timerCount_r;
    logic        timerRunning_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            timerCount_r   <= 16'h0000;
            timerRunning_r <= 1'b0;
        end else begin
            timerCount_r   <= count_r;
            timerRunning_r <= running;
        end
    end

    assign sfrRdData     = sfrRdData_r;
    assign resetOutPin_n = resetOutPin_n_r;
    assign chipReset     = chipReset_r;
    assign resetInPinOut = resetInPinOut_r;
    assign resetInPinOe  = resetInPinOe_r;
    assign timerCount    = timerCount_r;
    assign timerRunning  = timerRunning_r;

endmodule : wdrm_top
